// ### logic/lfms_defines.svh
// Named constants for the laser fault monitor and shutdown block.
`ifndef LFMS_DEFINES_SVH
`define LFMS_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define LFMS_CLK_MHZ 125
`define LFMS_FILTER_US 10000
`define LFMS_FILTER_CYC (`LFMS_FILTER_US * `LFMS_CLK_MHZ)
`define LFMS_BLANK_STEP_US 500
`define LFMS_BLANK_STEP_CYC (`LFMS_BLANK_STEP_US * `LFMS_CLK_MHZ)
`define LFMS_PIN_SYNC_CYC 1

// ----------------------------------------------------------------------
// Register byte addresses and reset values
// ----------------------------------------------------------------------
`define LFMS_ADR_CONFIG 8'h00
`define LFMS_ADR_CONTROL 8'h04
`define LFMS_ADR_THRESH 8'h08
`define LFMS_ADR_STATUS 8'h0c
`define LFMS_RST_CONFIG 32'h0000_0000
`define LFMS_RST_THRESH 32'h0000_0000

// ----------------------------------------------------------------------
// Fault source indices (also mask bit positions in the config word)
// ----------------------------------------------------------------------
`define LFMS_SRC_SUPPLY 0
`define LFMS_SRC_DIODE 1
`define LFMS_SRC_BIAS 2
`define LFMS_SRC_TXPWR 3
`define LFMS_SRC_SAT 4
`define LFMS_SRC_EXT 5
`define LFMS_NUM_SRC 6
`define LFMS_NUM_CMP 4

// ----------------------------------------------------------------------
// Config word fields
// ----------------------------------------------------------------------
`define LFMS_CFG_MASK_LSB 0
`define LFMS_CFG_OE 8
`define LFMS_CFG_SHUTDOWN_POLARITY 9
`define LFMS_CFG_BIASREF 10
`define LFMS_CFG_MODREF 11
`define LFMS_CFG_EXTMODE 12
`define LFMS_CFG_EXTPOL 13
`define LFMS_CFG_LOS_DETECTOR_DISABLE 14
`define LFMS_CFG_ZONE 15

// ----------------------------------------------------------------------
// Threshold word fields and status word fields
// ----------------------------------------------------------------------
`define LFMS_THR_LOSA_LSB 0
`define LFMS_THR_LOSD_LSB 8
`define LFMS_THR_BLANK_LSB 16
`define LFMS_THR_BIAS_LSB 24
`define LFMS_ST_TXFAULT 8
`define LFMS_ST_RXLOS 9
`define LFMS_ST_DIODE 10
`define LFMS_ST_LASEROFF 11
`define LFMS_ST_HIALARM 12
`define LFMS_ST_HIWARN 13
`define LFMS_ST_TEMP_LSB 16
`define LFMS_TEMP_FULL_SCALE 8'h7f
`define LFMS_BYTE_MAX 10'sh0ff

`endif

// ### logic/lfms_pkg.sv
// Types shared by the laser fault monitor and shutdown block.
package lfms_pkg;

  // ----------------------------------------------------------------------
  // Saturation blanking states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LFMS_BLANK_OFF = 3'b001,
    LFMS_BLANK_RUN = 3'b010,
    LFMS_BLANK_DONE = 3'b100
  } lfms_blank_state_t;

  // One bit per fault source.
  typedef logic [5:0] lfms_fault_vec_t;

endpackage : lfms_pkg

// ### logic/lfms_glitch_filter.sv
// Two-stage synchroniser followed by a persistence counter.
`timescale 1ns/100ps
module lfms_glitch_filter #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic raw_i, // Asynchronous level to clean up.
  output logic level_o // Accepted level, from a flip-flop.
);

  // Last count before the level is accepted.
  localparam logic [20:0] LAST = 21'(CYCLES - 1);

  logic sync_a; // First synchroniser stage, read only by sync_b.
  logic sync_b; // Second synchroniser stage.
  logic [20:0] cnt; // Cycles the level has stood high.

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  // Two flops keep metastability away from the counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------------
  // Persistence counter
  // ----------------------------------------------------------------------
  // Any drop restarts the count, so only an unbroken high level passes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 21'h000000;
      level_o <= 1'b0;
    end
    else if (!sync_b)
    begin
      cnt <= 21'h000000;
      level_o <= 1'b0;
    end
    else if (cnt == LAST)
    begin
      level_o <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 21'h000001;
    end
  end

endmodule : lfms_glitch_filter

// ### logic/lfms_top.sv
// Laser fault supervision, shutdown drive and loss-of-signal detection.
// Behaviour
// - Enabled fault shuts laser, asserts fault immediately.
// - Each fault source individually maskable.
// - Saturation ignored for programmable blanking after turn-on.
// - Out-of-range temperature path flags diode fault.
// - Loss-of-signal asserts low, releases above second threshold.
// - Detector disable releases the loss-of-signal line.
// - Status always shows loss-of-signal pin level.
// - Comparator glitches under ten milliseconds rejected.
// - Bias threshold offset by compensation table entry.
// - On fault outputs take configured shutdown states.
// - Shutdown active on disable pin, soft bit, fault.
// - Shutdown pin push-pull with selectable polarity.
// - Shared pin becomes external fault input, polarity selectable.
// - External fault ORed into transmit fault.
// - Diode fault forces full-scale temperature and flags.
// - Full-scale temperature held while diode fault persists.
// - Transmit disable toggle clears latched faults.
// - Diode detection waits for first conversion.
// - No diode fault reported while transmit disable pin high; soft disable bit does not block it.
// - Config bit selects internal or external temperature.
// - Outputs float unless enabled; levels follow polarity bits.
`timescale 1ns/100ps
`include "lfms_defines.svh"
module lfms_top import lfms_pkg::*; #(
  parameter int unsigned FILTER_CYCLES = `LFMS_FILTER_CYC, // Glitch filter length.
  parameter int unsigned BLANK_STEP_CYCLES = `LFMS_BLANK_STEP_CYC // One blanking step.
) (
  input wire logic clk_i, // System clock, 125 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic supply_cmp_i, // Supply low comparator, async.
  input wire logic bias_cmp_i, // Bias current high comparator, async.
  input wire logic tx_power_cmp_i, // Transmit power comparator, async.
  input wire logic saturation_cmp_i, // Loop saturation comparator, async.
  input wire logic diode_range_err_i, // Temperature path out of range.
  input wire logic conv_done_i, // Conversion cycle finished, pulse.
  input wire logic [7:0] temp_internal_i, // On-chip sensor reading.
  input wire logic [7:0] external_junction_input_i, // External junction reading.
  input wire logic [7:0] rx_power_level_input_i, // Received power sample.
  input wire logic [7:0] comp_lut_offset_i, // Signed compensation entry.
  input wire logic tx_disable_i, // Host transmit disable pin.
  input wire logic rxlos_i, // Level seen on the loss-of-signal pin.
  input wire logic shared_pin_i, // Level seen on the shared pin.
  output logic rxlos_o, // Loss-of-signal drive level.
  output logic rxlos_oe_o, // Loss-of-signal drive enable.
  output logic tx_fault_o, // Transmit fault to host.
  output logic laser_safety_shutdown_out_o, // Shared pin drive level.
  output logic shared_pin_oe_o, // Shared pin drive enable.
  output logic modulation_drive_out_o, // Modulation shutdown level.
  output logic modulation_drive_shut_o, // Modulation forced to shutdown.
  output logic modulation_drive_oe_o, // Modulation output enable.
  output logic bias_drive_out_o, // Bias shutdown level.
  output logic bias_drive_shut_o, // Bias forced to shutdown.
  output logic bias_drive_oe_o, // Bias output enable.
  output logic [7:0] bias_fault_threshold_o, // Compensated bias threshold.
  output logic [7:0] temp_report_o, // Reported temperature.
  output logic temp_high_alarm_o, // High temperature alarm.
  output logic temp_high_warn_o // High temperature warning.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] cfg; // Config word: masks, polarities, modes.
  logic soft_tx_disable; // Software transmit disable.
  logic [31:0] thresh; // Thresholds and blanking interval.
  logic [31:0] status; // Status word seen by reads.
  logic [31:0] rd_mux; // Read data before registering.
  logic [`LFMS_NUM_CMP-1:0] cmp_raw; // Comparator levels from pins.
  logic [`LFMS_NUM_CMP-1:0] cmp_ok; // Comparator levels after filter.
  logic [2:0] pin_raw; // Slow pins needing a synchroniser.
  logic [2:0] pin_s; // Synchronised slow pins.
  logic tx_dis_s; // Synchronised transmit disable.
  logic rxlos_s; // Synchronised loss-of-signal pin.
  logic shared_s; // Synchronised shared pin.
  logic tx_dis_q; // Previous transmit disable for edge detect.
  logic fault_clear; // Release edge of the disable toggle.
  logic bus_req; // Wishbone request present.
  logic first_conv; // First conversion has completed.
  lfms_fault_vec_t src; // Fault events after the mask bits, before latching.
  lfms_fault_vec_t latched; // Latched fault events.
  logic diode_flag; // Sense diode fault flag.
  logic any_fault; // Some latched fault is present.
  logic laser_off; // The laser is supposed to be off.
  logic los; // Loss-of-signal detector state.
  lfms_blank_state_t blank_state; // Saturation blanking state.
  logic [15:0] blank_pre; // Cycles within the current step.
  logic [7:0] blank_steps; // Steps elapsed since turn-on.
  logic signed [9:0] bias_sum; // Threshold plus signed offset.

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign cmp_raw = {saturation_cmp_i, tx_power_cmp_i, bias_cmp_i, supply_cmp_i};
  assign pin_raw = {shared_pin_i, rxlos_i, tx_disable_i};
  assign tx_dis_s = pin_s[0];
  assign rxlos_s = pin_s[1];
  assign shared_s = pin_s[2];
  assign fault_clear = tx_dis_q & ~tx_dis_s;
  assign any_fault = |latched;
  assign laser_off = tx_dis_s | soft_tx_disable | any_fault;

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  // Comparators run through the long filter; plain pins only get synced.
  genvar gi;
  generate
    for (gi = 0; gi < `LFMS_NUM_CMP; gi = gi + 1)
    begin : g_cmp
      lfms_glitch_filter #(.CYCLES(FILTER_CYCLES)) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(cmp_raw[gi]),
        .level_o(cmp_ok[gi])
      );
    end
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      lfms_glitch_filter #(.CYCLES(`LFMS_PIN_SYNC_CYC)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(pin_raw[gi]),
        .level_o(pin_s[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  // Byte-lane merge so that a partial write keeps the other lanes.
  function automatic logic [31:0] lfms_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : lfms_merge

  // Status word; unused bits read as zero.
  always_comb
  begin
    status = 32'h0000_0000;
    status[`LFMS_NUM_SRC-1:0] = latched;
    status[`LFMS_ST_TXFAULT] = tx_fault_o;
    status[`LFMS_ST_RXLOS] = rxlos_s;
    status[`LFMS_ST_DIODE] = diode_flag;
    status[`LFMS_ST_LASEROFF] = laser_off;
    status[`LFMS_ST_HIALARM] = temp_high_alarm_o;
    status[`LFMS_ST_HIWARN] = temp_high_warn_o;
    status[`LFMS_ST_TEMP_LSB +: 8] = temp_report_o;
  end

  // Read decode; an unmapped address reads zero but is still acknowledged.
  always_comb
  begin
    unique case (wb_adr_i)
      `LFMS_ADR_CONFIG: rd_mux = cfg;
      `LFMS_ADR_CONTROL: rd_mux = {31'h00000000, soft_tx_disable};
      `LFMS_ADR_THRESH: rd_mux = thresh;
      `LFMS_ADR_STATUS: rd_mux = status;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o)
      begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Writes land on the edge where the master sees ack, never earlier.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= `LFMS_RST_CONFIG;
      thresh <= `LFMS_RST_THRESH;
      soft_tx_disable <= 1'b0;
    end
    else if (bus_req & wb_ack_o & wb_we_i)
    begin
      if (wb_adr_i == `LFMS_ADR_CONFIG)
      begin
        cfg <= lfms_merge(cfg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `LFMS_ADR_THRESH)
      begin
        thresh <= lfms_merge(thresh, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `LFMS_ADR_CONTROL && wb_sel_i[0])
      begin
        soft_tx_disable <= wb_dat_i[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Saturation blanking
  // ----------------------------------------------------------------------
  // The loop voltage sits near zero right after turn-on, so saturation
  // would trip falsely; it is ignored until the programmed steps pass.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      blank_state <= LFMS_BLANK_OFF;
      blank_pre <= 16'h0000;
      blank_steps <= 8'h00;
    end
    else if (laser_off)
    begin
      blank_state <= LFMS_BLANK_OFF;
      blank_pre <= 16'h0000;
      blank_steps <= 8'h00;
    end
    else
    begin
      unique case (blank_state)
        LFMS_BLANK_OFF:
        begin
          blank_state <= LFMS_BLANK_RUN;
        end
        LFMS_BLANK_RUN:
        begin
          if (blank_steps >= thresh[`LFMS_THR_BLANK_LSB +: 8])
          begin
            blank_state <= LFMS_BLANK_DONE;
          end
          else if (blank_pre == 16'(BLANK_STEP_CYCLES - 1))
          begin
            blank_pre <= 16'h0000;
            blank_steps <= blank_steps + 8'h01;
          end
          else
          begin
            blank_pre <= blank_pre + 16'h0001;
          end
        end
        LFMS_BLANK_DONE:
        begin
          blank_state <= LFMS_BLANK_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fault sources
  // ----------------------------------------------------------------------
  // Mask bits remove a source before it can latch or shut anything down; diode_flag still latches a masked diode event.
  always_comb
  begin
    src = '0;
    src[`LFMS_SRC_SUPPLY] = cmp_ok[0];
    src[`LFMS_SRC_BIAS] = cmp_ok[1];
    src[`LFMS_SRC_TXPWR] = cmp_ok[2];
    src[`LFMS_SRC_SAT] = cmp_ok[3] & (blank_state == LFMS_BLANK_DONE);
    src[`LFMS_SRC_DIODE] = diode_range_err_i & first_conv & ~tx_dis_s;
    src[`LFMS_SRC_EXT] = cfg[`LFMS_CFG_EXTMODE] &
                         (shared_s == cfg[`LFMS_CFG_EXTPOL]);
    src = src & ~cfg[`LFMS_CFG_MASK_LSB +: `LFMS_NUM_SRC];
  end

  // Edge memory for the disable toggle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_dis_q <= 1'b0;
    end
    else
    begin
      tx_dis_q <= tx_dis_s;
    end
  end

  // Diode detection is held off until a conversion has really finished.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_conv <= 1'b0;
    end
    else if (conv_done_i)
    begin
      first_conv <= 1'b1;
    end
  end

  // Latches clear on the release of the disable toggle; a new event
  // in that same cycle wins, so nothing is lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latched <= '0;
      diode_flag <= 1'b0;
    end
    else
    begin
      latched <= (latched & ~{`LFMS_NUM_SRC{fault_clear}}) | src;
      if (diode_range_err_i & first_conv & ~tx_dis_s)
      begin
        diode_flag <= 1'b1;
      end
      else if (fault_clear)
      begin
        diode_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Loss-of-signal detector
  // ----------------------------------------------------------------------
  // Two thresholds give hysteresis so noise near one level cannot chatter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      los <= 1'b0;
    end
    else if (rx_power_level_input_i < thresh[`LFMS_THR_LOSA_LSB +: 8])
    begin
      los <= 1'b1;
    end
    else if (rx_power_level_input_i > thresh[`LFMS_THR_LOSD_LSB +: 8])
    begin
      los <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Temperature report and bias threshold
  // ----------------------------------------------------------------------
  assign bias_sum = $signed({2'b00, thresh[`LFMS_THR_BIAS_LSB +: 8]}) +
                    $signed({{2{comp_lut_offset_i[7]}}, comp_lut_offset_i});

  // Full scale is held for the whole life of the diode flag.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      temp_report_o <= 8'h00;
      temp_high_alarm_o <= 1'b0;
      temp_high_warn_o <= 1'b0;
      bias_fault_threshold_o <= 8'h00;
    end
    else
    begin
      if (diode_flag)
      begin
        temp_report_o <= `LFMS_TEMP_FULL_SCALE;
      end
      else if (cfg[`LFMS_CFG_ZONE])
      begin
        temp_report_o <= external_junction_input_i;
      end
      else
      begin
        temp_report_o <= temp_internal_i;
      end
      temp_high_alarm_o <= diode_flag;
      temp_high_warn_o <= diode_flag;
      // The sum saturates rather than wrapping into a wrong threshold.
      if (bias_sum < 10'sh000)
      begin
        bias_fault_threshold_o <= 8'h00;
      end
      else if (bias_sum > `LFMS_BYTE_MAX)
      begin
        bias_fault_threshold_o <= 8'hff;
      end
      else
      begin
        bias_fault_threshold_o <= bias_sum[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  // With the enable clear all laser outputs float, the safe shipped state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_fault_o <= 1'b0;
      rxlos_o <= 1'b0;
      rxlos_oe_o <= 1'b0;
      laser_safety_shutdown_out_o <= 1'b0;
      shared_pin_oe_o <= 1'b0;
      modulation_drive_out_o <= 1'b0;
      modulation_drive_shut_o <= 1'b0;
      modulation_drive_oe_o <= 1'b0;
      bias_drive_out_o <= 1'b0;
      bias_drive_shut_o <= 1'b0;
      bias_drive_oe_o <= 1'b0;
    end
    else
    begin
      tx_fault_o <= any_fault;
      rxlos_o <= los;
      rxlos_oe_o <= ~cfg[`LFMS_CFG_LOS_DETECTOR_DISABLE];
      // Active level equals the polarity bit; idle level is its inverse.
      laser_safety_shutdown_out_o <= laser_off ? cfg[`LFMS_CFG_SHUTDOWN_POLARITY]
                                               : ~cfg[`LFMS_CFG_SHUTDOWN_POLARITY];
      shared_pin_oe_o <= cfg[`LFMS_CFG_OE] & ~cfg[`LFMS_CFG_EXTMODE];
      modulation_drive_out_o <= cfg[`LFMS_CFG_MODREF];
      modulation_drive_shut_o <= laser_off;
      modulation_drive_oe_o <= cfg[`LFMS_CFG_OE];
      bias_drive_out_o <= cfg[`LFMS_CFG_BIASREF];
      bias_drive_shut_o <= laser_off;
      bias_drive_oe_o <= cfg[`LFMS_CFG_OE];
    end
  end

endmodule : lfms_top

// ### tb/lfms_top_asserts.sv
// Port checker for the laser fault monitor.
`timescale 1ns/100ps
module lfms_top_asserts (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, // Clock, bus.
  input wire logic tx_disable_i, tx_fault_o, temp_high_alarm_o, // Pin, flags.
  input wire logic bias_drive_shut_o, modulation_drive_shut_o, // Shutdown.
  input wire logic bias_drive_oe_o, modulation_drive_oe_o, // Enables.
  input wire logic [7:0] temp_report_o // Temperature.
);
  // Cycles since the disable pin was last high; a clear must follow one.
  logic [3:0] since;
  always_ff @(posedge clk_i)
    if (rst_i) since <= 4'hf;
    else if (tx_disable_i) since <= 4'h0;
    else if (since != 4'hf) since <= since + 4'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_fault_shut: assert property (tx_fault_o |-> bias_drive_shut_o && modulation_drive_shut_o)
    else $error("no shutdown");
  a_temp_full: assert property (temp_high_alarm_o |-> temp_report_o == 8'h7f)
    else $error("temp not full");
  a_oe_pair: assert property (bias_drive_oe_o == modulation_drive_oe_o)
    else $error("enables differ");
  a_fault_hold: assert property (tx_fault_o && tx_disable_i |=> tx_fault_o)
    else $error("fault dropped");
  a_clear_cause: assert property ($fell(tx_fault_o) |-> since < 4'hc)
    else $error("clear without toggle");
  a_diode_quiet: assert property (tx_disable_i [*6] |=> !$rose(temp_high_alarm_o))
    else $error("diode while disabled");
endmodule : lfms_top_asserts

// ### tb/lfms_far.sv
// Host and laser driver side: pin levels and the fault reset toggle.
`timescale 1ns/100ps
module lfms_far (
  input wire logic clk_i, dis_i, clr_i, // Clock, hold disable, start toggle.
  input wire logic los_i, flt_i, // External loss and fault levels.
  input wire logic [3:0] dev_i, // Shared oe, level; rxlos oe, level.
  output logic txd_o, rxlos_pin_o, shared_pin_o // Pin levels.
);
  // Toggle long enough to pass the pin synchroniser.
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge clk_i)
    if (clr_i) cnt <= 4'h8;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  assign txd_o = dis_i || cnt != 4'h0;
  assign rxlos_pin_o = dev_i[1] ? dev_i[0] : los_i;
  assign shared_pin_o = dev_i[3] ? dev_i[2] : flt_i;
endmodule : lfms_far

// ### tb/tb.sv
// Self-checking bench for the laser fault monitor.
`timescale 1ns/100ps
module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic diode_range_err_i = 0, conv_done_i = 0, tx_disable_i, rxlos_i, shared_pin_i;
  logic rxlos_o, rxlos_oe_o, tx_fault_o, laser_safety_shutdown_out_o, shared_pin_oe_o;
  logic modulation_drive_out_o, modulation_drive_shut_o, modulation_drive_oe_o;
  logic bias_drive_out_o, bias_drive_shut_o, bias_drive_oe_o, temp_high_alarm_o;
  logic temp_high_warn_o, dis = 0, clr = 0, los = 0, flt = 0;
  logic [3:0] c = 0, wb_sel_i = 4'hf;
  logic [7:0] wb_adr_i = 0, temp_internal_i = 8'h19, external_junction_input_i = 8'h2a;
  logic [7:0] rx_power_level_input_i = 8'h90, comp_lut_offset_i = 0, v;
  logic [7:0] bias_fault_threshold_o, temp_report_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o, m, q_e[$], q_m[$]; // Expected reads.
  int errors = 0, cmp_count = 0, seed = 32'h4e64;
  wire supply_cmp_i = c[0], bias_cmp_i = c[1], tx_power_cmp_i = c[2], saturation_cmp_i = c[3];
  lfms_top #(.FILTER_CYCLES(16), .BLANK_STEP_CYCLES(4)) u_dut (.*);
  lfms_far u_far (.clk_i, .dis_i(dis), .clr_i(clr), .los_i(los), .flt_i(flt),
    .dev_i({shared_pin_oe_o, laser_safety_shutdown_out_o, rxlos_oe_o, rxlos_o}),
    .txd_o(tx_disable_i), .rxlos_pin_o(rxlos_i), .shared_pin_o(shared_pin_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic fail(input string s);
    errors++;
    $display("[ERR] %0t %s", $time, s);
  endtask : fail
  task automatic ck(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) fail("mismatch");
  endtask : ck
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk
  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Single cycle; a read notes its expected word and mask.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, k);
    int n = 0;
    tk(1);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    if (!we) q_e.push_back(d);
    if (!we) q_m.push_back(k);
    do tk(1); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) fail("no ack");
    if (n >= 50) end_sim();
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic hold(input int i, n);
    c[i] <= 1'b1;
    tk(n);
    c[i] <= 1'b0;
    tk(24);
  endtask : hold
  task automatic tgl;
    clr <= 1;
    tk(1);
    clr <= 0;
    tk(20);
  endtask : tgl
  // Read data is compared at the acknowledge edge.
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_e.size() > 0)
    begin
      m = q_m.pop_front();
      ck(wb_dat_o & m, q_e.pop_front() & m);
    end
  initial
  begin
    tk(12);
    rst_i <= 0;
    wb(0, 8'h00, 0, '1);
    wb(1, 8'h0c, '1, 0);
    wb(0, 8'hf0, 0, '1);
    wb(1, 8'h00, 32'h700, 0);
    wb(1, 8'h08, 32'h80ff8040, 0);
    hold(0, 10);
    ck({tx_fault_o, bias_drive_oe_o}, 1);
    hold(0, 24);
    ck({tx_fault_o, bias_drive_out_o, modulation_drive_out_o}, 6);
    ck(laser_safety_shutdown_out_o, 1);
    tgl();
    ck(tx_fault_o, 0);
    wb(1, 8'h00, 32'h701, 0);
    hold(0, 24);
    ck(tx_fault_o, 0);
    hold(1, 24);
    ck(tx_fault_o, 1);
    tgl();
    hold(3, 40);
    ck(tx_fault_o, 0);
    tk(1000);
    hold(3, 24);
    ck(tx_fault_o, 1);
    tgl();
    $display("fault path done");
    diode_range_err_i <= 1;
    tk(30);
    ck(temp_high_alarm_o, 0);
    conv_done_i <= 1;
    tk(1);
    conv_done_i <= 0;
    tk(30);
    ck({tx_fault_o, temp_high_warn_o, temp_report_o}, 10'h37f);
    diode_range_err_i <= 0;
    tgl();
    dis <= 1;
    tk(6);
    diode_range_err_i <= 1;
    tk(30);
    ck({temp_high_alarm_o, temp_report_o}, 9'h019);
    diode_range_err_i <= 0;
    dis <= 0;
    wb(1, 8'h00, 32'h8701, 0);
    tk(30);
    ck(temp_report_o, 8'h2a);
    $display("diode path done");
    repeat (3)
    begin
      v = 8'($random(seed));
      rx_power_level_input_i <= {2'b00, v[5:0]};
      tk(4);
      ck(rxlos_o, 1);
      rx_power_level_input_i <= {2'b01, v[5:0]};
      tk(4);
      ck(rxlos_o, 1);
      rx_power_level_input_i <= {2'b10, v[5:0]} + 8'h01;
      tk(4);
      ck(rxlos_o, 0);
    end
    wb(1, 8'h00, 32'hf701, 0);
    los <= 1;
    flt <= 1;
    tk(40);
    ck({rxlos_oe_o, shared_pin_oe_o, tx_fault_o}, 1);
    wb(0, 8'h0c, 32'h300, 32'h300);
    $display("los path done");
    flt <= 0;
    tgl();
    wb(1, 8'h04, 1, 0);
    tk(4);
    ck({laser_safety_shutdown_out_o, bias_drive_shut_o}, 3);
    // Polarity bit cleared, shared pin back to output: the off level is low.
    wb(1, 8'h00, 32'h501, 0);
    tk(4);
    ck({laser_safety_shutdown_out_o, shared_pin_oe_o}, 1);
    $display("shutdown path done");
    repeat (3)
    begin
      v = 8'($random(seed));
      comp_lut_offset_i <= v;
      tk(3);
      ck(bias_fault_threshold_o, {~v[7], v[6:0]});
    end
    $display("bias path done");
    end_sim();
  end
  initial
  begin
    #200000;
    fail("timeout");
    end_sim();
  end
endmodule : tb
bind lfms_top lfms_top_asserts u_chk (.*);
